// ---- core/ds_pkg.sv ----
/*
  Constants and types for the data-space access block: address map,
  working register layout, reset values, access modes and extend ops.
  Assumes a 16-bit byte-addressed data space and a single system clock.
*/
package ds_pkg;

  // ------------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int ADDR_W = 16;
  localparam int NEAR_W = 13;
  localparam int GP_COUNT = 8;
  localparam int GP_IDX_W = 3;
  localparam int RAM_IDX_W = 14;

  // ------------------------------------------------------------------
  // Address map
  // ------------------------------------------------------------------
  localparam logic [15:0] SFR_BASE = 16'h0000;
  localparam logic [15:0] SFR_TOP = 16'h07FF;
  localparam logic [15:0] NEAR_TOP = 16'h1FFF;
  localparam logic [15:0] RAM_BASE = 16'h0800;
  localparam logic [15:0] RAM_TOP = 16'h67FF;
  localparam logic [15:0] EDS_BASE = 16'h8000;
  localparam logic [15:0] GP_REG_0 = 16'h0000;
  localparam logic [15:0] GP_REG_1 = 16'h0002;
  localparam logic [15:0] GP_REG_2 = 16'h0004;
  localparam logic [15:0] GP_REG_3 = 16'h0006;
  localparam logic [15:0] GP_REG_4 = 16'h0008;
  localparam logic [15:0] GP_REG_5 = 16'h000A;
  localparam logic [15:0] GP_REG_6 = 16'h000C;
  localparam logic [15:0] GP_REG_7 = 16'h000E;
  localparam logic [15:0] GP_REG_TOP = 16'h000F;
  localparam int GRANULE_LSB = 5;
  localparam int GRANULE_MSB = 10;
  localparam logic [5:0] CORE_GRANULE = 6'h00;

  // ------------------------------------------------------------------
  // Reset values and steps
  // ------------------------------------------------------------------
  localparam logic [15:0] GP_RESET = 16'h0000;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] WORD_ZERO = 16'h0000;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_INDIRECT = 2'b00,
    MODE_NEAR = 2'b01,
    MODE_MOV = 2'b10
  } addr_mode_t;

  typedef enum logic [1:0] {
    EXT_NONE = 2'b00,
    SIGN_EXTEND_OP = 2'b01,
    ZERO_EXTEND_OP = 2'b10
  } ext_op_t;

  typedef enum logic [1:0] {
    SRC_ZERO = 2'b00,
    SRC_GP = 2'b01,
    SRC_RAM = 2'b10
  } read_src_t;

endpackage : ds_pkg

// ---- core/mem_port_if.sv ----
/*
  Word port between the access logic and the data RAM array.
  Assumes both ends run on the same clock; read data is registered.
*/
`timescale 1ns/1ps
interface mem_port_if;
  logic [ds_pkg::RAM_IDX_W-1:0] idx;
  logic wr_lo;
  logic wr_hi;
  logic [15:0] wdata;
  logic [15:0] rdata;

  modport ctrl (output idx, output wr_lo, output wr_hi, output wdata, input rdata);
  modport mem (input idx, input wr_lo, input wr_hi, input wdata, output rdata);
endinterface : mem_port_if

// ---- core/ds_ram.sv ----
/*
  Data RAM as two parallel byte-wide arrays with one word index and
  separate byte write lanes; read data comes out of a register.
  Assumes the caller masks writes outside the implemented range.
*/
`timescale 1ns/1ps
module ds_ram (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  mem_port_if.mem port
);
  import ds_pkg::*;

  localparam int DEPTH = 12288;

  logic [7:0] lo_bank [DEPTH];
  logic [7:0] hi_bank [DEPTH];

  always_ff @(posedge ref_clk_in) begin
    if (port.wr_lo) begin
      lo_bank[port.idx] <= port.wdata[7:0];
    end
    if (port.wr_hi) begin
      hi_bank[port.idx] <= port.wdata[15:8];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      port.rdata <= WORD_ZERO;
    end else begin
      port.rdata <= {hi_bank[port.idx], lo_bank[port.idx]};
    end
  end
endmodule : ds_ram

// ---- core/data_space_access.sv ----
/*
  Data-space access logic: byte/word reads and writes, misalignment
  trap, working registers 0..7, sign/zero extend, address decode.
  Assumes the execution unit presents one request per cycle and
  watches addr_err_out to take the trap after the instruction.
*/
// Functional notes
// - Words byte-addressed, low byte at even address
// - Post-increment adds one for byte, two word
// - Byte read selects by bit 0, low lane
// - Shared word decode, separate byte write strobes
// - Odd-address word access raises address error
// - Misaligned read completes; misaligned write suppressed
// - Byte load changes only register low byte
// - Sign extend copies bit 7 upward
// - Zero extend clears register upper byte
// - Near space 0000-1FFF via 13-bit field
// - Move mode reaches whole space, 16-bit field
// - 0000-07FF decoded as special function region
// - Unimplemented special function addresses read zero
// - Region decoded in 32-byte granules, core lowest
// - Data RAM implemented only up to 67FF
// - 8000-FFFF is extended window, not RAM
`timescale 1ns/1ps
module data_space_access (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic req_byte_in,
  input wire ds_pkg::addr_mode_t req_mode_in,
  input wire logic [15:0] req_addr_in,
  input wire logic [15:0] req_wdata_in,
  input wire logic load_valid_in,
  input wire logic load_byte_in,
  input wire logic [2:0] load_reg_in,
  input wire logic [15:0] load_data_in,
  input wire ds_pkg::ext_op_t ext_op_in,
  input wire logic [2:0] ext_reg_in,
  output logic [15:0] rdata_out,
  output logic rvalid_out,
  output logic addr_err_out,
  output logic [15:0] ptr_next_out,
  output logic near_hit_out,
  output logic eds_hit_out
);
  import ds_pkg::*;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [15:0] step_of(input logic is_byte);
    step_of = is_byte ? STEP_BYTE : STEP_WORD;
  endfunction : step_of

  function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic hi);
    pick_byte = hi ? w[15:8] : w[7:0];
  endfunction : pick_byte

  function automatic logic [15:0] sign_ext(input logic [15:0] w);
    sign_ext = {{8{w[7]}}, w[7:0]};
  endfunction : sign_ext

  function automatic logic [15:0] zero_ext(input logic [15:0] w);
    zero_ext = {BYTE_ZERO, w[7:0]};
  endfunction : zero_ext

  // ------------------------------------------------------------------
  // Effective address and decode
  // ------------------------------------------------------------------
  wire logic [15:0] near_ea = {3'b000, req_addr_in[NEAR_W-1:0]};
  wire logic [15:0] ea = (req_mode_in == MODE_NEAR) ? near_ea
                       : req_addr_in;
  wire logic odd_addr = ea[0];
  wire logic misaligned = req_valid_in && !req_byte_in && odd_addr;
  wire logic [15:0] word_ea = {ea[15:1], 1'b0};

  wire logic is_sfr = (word_ea >= SFR_BASE) && (word_ea <= SFR_TOP);
  wire logic [5:0] granule = ea[GRANULE_MSB:GRANULE_LSB];
  wire logic core_granule = is_sfr && (granule == CORE_GRANULE);
  wire logic is_gp = core_granule && (word_ea <= GP_REG_TOP);
  wire logic [2:0] gp_idx = ea[3:1];
  wire logic is_eds = (word_ea >= EDS_BASE);
  wire logic is_ram = !is_eds && (word_ea >= RAM_BASE) && (word_ea <= RAM_TOP);
  wire logic is_near = (word_ea <= NEAR_TOP);
  wire logic [15:0] ram_off = word_ea - RAM_BASE;
  wire logic [RAM_IDX_W-1:0] ram_idx = ram_off[RAM_IDX_W:1];

  // ------------------------------------------------------------------
  // Write lanes
  // ------------------------------------------------------------------
  wire logic wr_ok = req_valid_in && req_write_in && !misaligned;
  wire logic lane_lo = !req_byte_in || !odd_addr;
  wire logic lane_hi = !req_byte_in || odd_addr;
  wire logic [15:0] lane_data = req_byte_in ? {2{req_wdata_in[7:0]}} : req_wdata_in;
  wire logic gp_wr = wr_ok && is_gp;
  wire logic ram_wr = wr_ok && is_ram;
  wire logic rd_req = req_valid_in && !req_write_in;

  wire read_src_t src_sel = is_gp ? SRC_GP
                          : is_ram ? SRC_RAM
                          : SRC_ZERO;

  // ------------------------------------------------------------------
  // RAM array
  // ------------------------------------------------------------------
  mem_port_if mport ();

  assign mport.idx = ram_idx;
  assign mport.wr_lo = ram_wr && lane_lo;
  assign mport.wr_hi = ram_wr && lane_hi;
  assign mport.wdata = lane_data;

  ds_ram u_ram (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .port(mport)
  );

  // ------------------------------------------------------------------
  // Working registers
  // ------------------------------------------------------------------
  logic [15:0] gp_reg [GP_COUNT];
  logic [15:0] next_gp_reg [GP_COUNT];

  always_comb begin
    for (int i = 0; i < GP_COUNT; i++) begin
      next_gp_reg[i] = gp_reg[i];
      if (ext_op_in == SIGN_EXTEND_OP && ext_reg_in == GP_IDX_W'(i)) begin
        next_gp_reg[i] = sign_ext(gp_reg[i]);
      end else if (ext_op_in == ZERO_EXTEND_OP && ext_reg_in == GP_IDX_W'(i)) begin
        next_gp_reg[i] = zero_ext(gp_reg[i]);
      end
      if (load_valid_in && load_reg_in == GP_IDX_W'(i)) begin
        if (load_byte_in) begin
          next_gp_reg[i] = {gp_reg[i][15:8], load_data_in[7:0]};
        end else begin
          next_gp_reg[i] = load_data_in;
        end
      end
      if (gp_wr && gp_idx == GP_IDX_W'(i)) begin
        if (lane_lo) begin
          next_gp_reg[i][7:0] = lane_data[7:0];
        end
        if (lane_hi) begin
          next_gp_reg[i][15:8] = lane_data[15:8];
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    for (int i = 0; i < GP_COUNT; i++) begin
      if (!rst_n_in) begin
        gp_reg[i] <= GP_RESET;
      end else begin
        gp_reg[i] <= next_gp_reg[i];
      end
    end
  end

  // ------------------------------------------------------------------
  // Read pipeline: stage one captures the source, stage two the lane
  // ------------------------------------------------------------------
  logic s1_valid;
  logic s1_byte;
  logic s1_hi;
  read_src_t s1_src;
  logic [15:0] s1_gp;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      s1_valid <= 1'b0;
      s1_byte <= 1'b0;
      s1_hi <= 1'b0;
      s1_src <= SRC_ZERO;
      s1_gp <= WORD_ZERO;
    end else begin
      s1_valid <= rd_req;
      s1_byte <= req_byte_in;
      s1_hi <= odd_addr;
      s1_src <= src_sel;
      s1_gp <= gp_reg[gp_idx];
    end
  end

  wire logic [15:0] s1_word = (s1_src == SRC_GP) ? s1_gp
                            : (s1_src == SRC_RAM) ? mport.rdata
                            : WORD_ZERO;
  wire logic [15:0] s1_data = s1_byte ? {BYTE_ZERO, pick_byte(s1_word, s1_hi)}
                            : s1_word;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      rdata_out <= WORD_ZERO;
      rvalid_out <= 1'b0;
    end else begin
      rvalid_out <= s1_valid;
      if (s1_valid) begin
        rdata_out <= s1_data;
      end
    end
  end

  // ------------------------------------------------------------------
  // Pointer update and decode flags
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      ptr_next_out <= WORD_ZERO;
      near_hit_out <= 1'b0;
      eds_hit_out <= 1'b0;
    end else begin
      if (req_valid_in) begin
        ptr_next_out <= ea + step_of(req_byte_in);
      end
      near_hit_out <= req_valid_in && is_near;
      eds_hit_out <= req_valid_in && is_eds;
    end
  end

  // ------------------------------------------------------------------
  // Trap report
  // ------------------------------------------------------------------
  assign addr_err_out = misaligned;

endmodule : data_space_access

// ---- bench/ds_sva.sv ----
/* Port checker for data_space_access.
   Assumes ds_pkg is compiled first; bound below. */
`timescale 1ns/1ps
module ds_sva (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic req_byte_in,
  input wire ds_pkg::addr_mode_t req_mode_in,
  input wire logic [15:0] req_addr_in,
  input wire logic [15:0] rdata_out,
  input wire logic rvalid_out,
  input wire logic addr_err_out,
  input wire logic [15:0] ptr_next_out,
  input wire logic near_hit_out,
  input wire logic eds_hit_out
);
  import ds_pkg::*;
  wire logic [15:0] eff = (req_mode_in == MODE_NEAR) ? {3'h0, req_addr_in[12:0]} : req_addr_in;
  wire logic rd = req_valid_in && !req_write_in;
  wire logic dead = (eff > GP_REG_TOP && eff <= SFR_TOP) || eff > RAM_TOP;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_rd_latency: assert property (rd |-> ##2 rvalid_out)
    else $error("read answer late");
  a_no_stray: assert property (rvalid_out |-> $past(rd, 2))
    else $error("stray read answer");
  a_odd_word: assert property (addr_err_out == (req_valid_in && !req_byte_in && eff[0]))
    else $error("address error wrong");
  a_ptr_step: assert property (req_valid_in |=> ptr_next_out ==
    $past(eff) + ($past(req_byte_in) ? STEP_BYTE : STEP_WORD)) else $error("pointer step wrong");
  a_near_hit: assert property (req_valid_in |=> near_hit_out == ($past(eff) <= NEAR_TOP))
    else $error("near flag wrong");
  a_eds_hit: assert property (eds_hit_out == $past(req_valid_in && eff >= EDS_BASE))
    else $error("window flag wrong");
  a_byte_high: assert property (rd && req_byte_in |-> ##2 rdata_out[15:8] == BYTE_ZERO)
    else $error("byte read high lane set");
  a_dead_zero: assert property (rd && dead |-> ##2 rdata_out == WORD_ZERO)
    else $error("unimplemented read not zero");
  c_odd_wr: cover property (addr_err_out && req_write_in);
  c_near: cover property (req_valid_in && req_mode_in == MODE_NEAR);
  c_byte_rd: cover property (rd && req_byte_in ##2 rvalid_out);
endmodule : ds_sva
bind data_space_access ds_sva chk (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
  .req_valid_in(req_valid_in), .req_write_in(req_write_in), .req_byte_in(req_byte_in),
  .req_mode_in(req_mode_in), .req_addr_in(req_addr_in), .rdata_out(rdata_out),
  .rvalid_out(rvalid_out), .addr_err_out(addr_err_out), .ptr_next_out(ptr_next_out),
  .near_hit_out(near_hit_out), .eds_hit_out(eds_hit_out));

// ---- bench/core_model.sv ----
/* Execution unit model: access, load and extend requests.
   Assumes calls start just after a rising clock edge. */
`timescale 1ns/1ps
module core_model (
  input wire logic ref_clk_in,
  output logic req_valid_out,
  output logic req_write_out,
  output logic req_byte_out,
  output ds_pkg::addr_mode_t req_mode_out,
  output logic [15:0] req_addr_out,
  output logic [15:0] req_wdata_out,
  output logic load_valid_out,
  output logic load_byte_out,
  output logic [2:0] load_reg_out,
  output logic [15:0] load_data_out,
  output ds_pkg::ext_op_t ext_op_out,
  output logic [2:0] ext_reg_out
);
  import ds_pkg::*;
  initial {req_valid_out, req_write_out, req_byte_out, load_valid_out, load_byte_out} = 5'h00;
  initial {req_mode_out, req_addr_out, req_wdata_out, load_reg_out, load_data_out} = 53'h0;
  initial {ext_op_out, ext_reg_out} = {EXT_NONE, 3'h0};
  // Held until the next call; odd word addresses only when asked
  task automatic access(input logic w, input logic b, input addr_mode_t m,
    input logic [15:0] a, input logic [15:0] d);
    {req_valid_out, req_write_out, req_byte_out, req_mode_out} = {1'b1, w, b, m};
    {req_addr_out, req_wdata_out} = {a, d};
    @(posedge ref_clk_in) #1;
  endtask : access
  task automatic idle();
    req_valid_out = 1'b0;
    req_addr_out = ~req_addr_out;
    @(posedge ref_clk_in) #1;
  endtask : idle
  task automatic load(input logic b, input logic [2:0] r, input logic [15:0] d);
    req_valid_out = 1'b0;
    {load_valid_out, load_byte_out, load_reg_out, load_data_out} = {1'b1, b, r, d};
    @(posedge ref_clk_in) #1 load_valid_out = 1'b0;
    @(posedge ref_clk_in) #1;
  endtask : load
  task automatic ext(input ext_op_t op, input logic [2:0] r);
    req_valid_out = 1'b0;
    {ext_op_out, ext_reg_out} = {op, r};
    @(posedge ref_clk_in) #1 ext_op_out = EXT_NONE;
    @(posedge ref_clk_in) #1;
  endtask : ext
endmodule : core_model

// ---- bench/tb.sv ----
/* Self-checking bench for data_space_access.
   Assumes ds_pkg, ds_sva and core_model are compiled first. */
`timescale 1ns/1ps
module tb;
  import ds_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic rv, rw, rb, lv, lb, rvalid, aerr, nh, eh;
  addr_mode_t rm;
  ext_op_t eo;
  logic [15:0] ra, rwd, ld_d, rdata, ptr;
  logic [2:0] lr, er;
  logic [15:0] model [int];
  logic [15:0] expq [$];
  logic [15:0] dead [5] = '{16'h0010, 16'h0020, 16'h07FE, 16'h6800, 16'h8000};
  int errors = 0;
  int total_checks = 0;
  always #4 ref_clk_in = ~ref_clk_in;
  core_model cpu (.ref_clk_in(ref_clk_in), .req_valid_out(rv), .req_write_out(rw),
    .req_byte_out(rb), .req_mode_out(rm), .req_addr_out(ra), .req_wdata_out(rwd),
    .load_valid_out(lv), .load_byte_out(lb), .load_reg_out(lr), .load_data_out(ld_d),
    .ext_op_out(eo), .ext_reg_out(er));
  data_space_access DUT (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .req_valid_in(rv),
    .req_write_in(rw), .req_byte_in(rb), .req_mode_in(rm), .req_addr_in(ra),
    .req_wdata_in(rwd), .load_valid_in(lv), .load_byte_in(lb), .load_reg_in(lr),
    .load_data_in(ld_d), .ext_op_in(eo), .ext_reg_in(er), .rdata_out(rdata),
    .rvalid_out(rvalid), .addr_err_out(aerr), .ptr_next_out(ptr), .near_hit_out(nh),
    .eds_hit_out(eh));
  function automatic logic [15:0] eff(input addr_mode_t m, input logic [15:0] a);
    return (m == MODE_NEAR) ? {3'h0, a[12:0]} : a;
  endfunction : eff
  function automatic logic live(input logic [15:0] a);
    return a <= GP_REG_TOP || (a >= RAM_BASE && a <= RAM_TOP);
  endfunction : live
  task automatic wr(input logic b, input addr_mode_t m, input logic [15:0] a, input logic [15:0] d);
    logic [15:0] e;
    e = eff(m, a);
    if (live(e) && (b || !e[0])) begin
      if (!b) model[e[15:1]] = d;
      else if (e[0]) model[e[15:1]][15:8] = d[7:0];
      else model[e[15:1]][7:0] = d[7:0];
    end
    cpu.access(1'b1, b, m, a, d);
  endtask : wr
  task automatic rd(input logic b, input addr_mode_t m, input logic [15:0] a);
    logic [15:0] e, w;
    e = eff(m, a);
    w = (live(e) && model.exists(int'(e[15:1]))) ? model[e[15:1]] : WORD_ZERO;
    expq.push_back(b ? {BYTE_ZERO, e[0] ? w[15:8] : w[7:0]} : w);
    cpu.access(1'b0, b, m, a, WORD_ZERO);
  endtask : rd
  task automatic chk_rd(input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t read %h expected %h", $time, got, exp);
    end
  endtask : chk_rd
  task automatic wrap_up();
    if (errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up
  always @(negedge ref_clk_in) begin
    if (rvalid === 1'b1) chk_rd(expq.size() != 0 ? expq.pop_front() : 16'hXXXX, rdata);
  end
  initial begin
    #400000 errors++;
    wrap_up();
  end
  initial begin
    logic [15:0] a, d;
    void'($urandom(32'h8A80));
    for (int i = 0; i < 8; i++) model[i] = GP_RESET;
    repeat (8) @(posedge ref_clk_in);
    #1 rst_n_in = 1'b1;
    for (int i = 0; i < 8; i++) rd(1'b0, MODE_INDIRECT, 16'(2 * i));
    for (int i = 0; i < 8; i++) begin
      a = RAM_BASE + 16'($urandom_range(12287) * 2);
      d = 16'($urandom);
      wr(1'b0, MODE_MOV, a, d);
      wr(1'b1, MODE_INDIRECT, a + 16'h0001, ~d);
      wr(1'b1, MODE_NEAR, 16'(2 * i + i % 2) | 16'hE000, d);
      rd(1'b0, MODE_MOV, a);
      rd(1'b1, MODE_INDIRECT, a + 16'h0001);
      rd(1'b1, MODE_INDIRECT, a);
      rd(1'b0, MODE_INDIRECT, a + 16'h0001);
      wr(1'b0, MODE_INDIRECT, a + 16'h0001, d + 16'h0001);
      rd(1'b0, MODE_INDIRECT, a);
      rd(1'b0, MODE_NEAR, 16'(2 * i) | 16'hE000);
    end
    foreach (dead[j]) begin
      wr(1'b0, MODE_MOV, dead[j], 16'hA5A5);
      rd(1'b0, MODE_MOV, dead[j]);
    end
    for (int r = 0; r < 8; r++) begin
      d = 16'($urandom);
      model[r] = d;
      cpu.load(1'b0, 3'(r), d);
      model[r][7:0] = 8'(r * 8'h21 + 8'h70);
      cpu.load(1'b1, 3'(r), {~d[15:8], model[r][7:0]});
      rd(1'b0, MODE_INDIRECT, 16'(2 * r));
      model[r][15:8] = r[0] ? {8{model[r][7]}} : BYTE_ZERO;
      cpu.ext(r[0] ? SIGN_EXTEND_OP : ZERO_EXTEND_OP, 3'(r));
      rd(1'b0, MODE_INDIRECT, 16'(2 * r));
    end
    cpu.idle();
    for (int i = 0; i < 20 && expq.size() != 0; i++) @(posedge ref_clk_in);
    if (expq.size() != 0) begin
      errors++;
      $display("CHECK FAILED %0t reads unanswered", $time);
    end
    wrap_up();
  end
endmodule : tb
